// File: ssp_pkg.sv
// shared constants, types and register map of the synchronous serial port
package ssp_pkg;

	// register byte offsets
	localparam logic [7:0] CTRL0_OFS = 8'h00;
	localparam logic [7:0] CTRL1_OFS = 8'h04;
	localparam logic [7:0] DATA_OFS = 8'h08;
	localparam logic [7:0] FLAGS_OFS = 8'h0C;
	localparam logic [7:0] PRESC_OFS = 8'h10;
	localparam logic [7:0] IMASK_OFS = 8'h14;
	localparam logic [7:0] ISTAT_OFS = 8'h18;

	// frame format register fields
	localparam int SIZE_LSB = 0;
	localparam int SCR_LSB = 8;
	localparam logic [3:0] SIZE_MIN = 4'h3;
	localparam logic [3:0] SIZE_RST = 4'h7;
	localparam logic [7:0] SCR_RST = 8'h00;
	localparam logic [7:0] PRESC_RST = 8'h00;

	// control register bit positions
	localparam int CR1_LOOPBACK = 0;
	localparam int CR1_ENABLE = 1;
	localparam int CR1_ROLE = 2;
	localparam int CR1_OUT_OFF = 3;

	// flag register bit positions
	localparam int FLAG_TX_EMPTY = 0;
	localparam int FLAG_TX_SPACE = 1;
	localparam int FLAG_RX_DATA = 2;
	localparam int FLAG_RX_FULL = 3;
	localparam int FLAG_BUSY = 4;

	// interrupt status and mask bit positions
	localparam int IRQ_OVERRUN = 0;
	localparam int IRQ_RX_WORD = 1;
	localparam int IRQ_TX_DONE = 2;
	localparam int IRQ_W = 3;
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

	// documented fifo shape
	localparam int FIFO_DEPTH_DEF = 8;
	localparam int DATA_W_DEF = 16;

	// control register 1 fields
	typedef struct packed {
		logic slave_output_off;
		logic role_select;
		logic port_enable;
		logic loopback_select;
	} ctrl1_s;

	localparam ctrl1_s CTRL1_RST = 4'h0;

	// link pins driven by the port
	typedef struct packed {
		logic sclk_out;
		logic sclk_oe;
		logic fss_out;
		logic fss_oe;
		logic serial_data_out_pin;
		logic serial_data_oe;
	} link_pins_s;

	localparam link_pins_s LINK_RST = 6'h08;

	typedef enum {LINK_IDLE, LINK_LOW, LINK_HIGH, LINK_SLAVE} link_state_e;

endpackage

// File: fifo_mem.sv
// word storage for one fifo, read data registered
`timescale 1ns/1ns
module fifo_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8,
	parameter int AW = 3
)(
	// clock
	input wire logic mclk,
	// write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// read side
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge mclk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

// File: ssp_ctrl_status.sv
// synchronous serial port: control, data fifos, flags and link shifter
// Operation
// - slave_output_off disables data output in slave
// - role_select chooses master or slave
// - port_enable switches the port on
// - loopback_select feeds tx shifter into rx
// - data writes push tx, reads pop rx
// - unused upper tx bits are ignored
// - received data right justified at bit 0
// - busy while shifting or tx fifo nonempty
// - rx_fifo_full flag
// - rx_fifo_not_empty flag
// - tx_fifo_not_full flag
// - tx_fifo_empty flag, one after reset
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module ssp_ctrl_status
	import ssp_pkg::*;
#(
	parameter int FIFO_DEPTH = ssp_pkg::FIFO_DEPTH_DEF,
	parameter int DATA_W = ssp_pkg::DATA_W_DEF
)(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// interrupt
	output logic irq,
	// link inputs
	input wire logic sclk_in,
	input wire logic fss_in,
	input wire logic serial_data_in,
	// link outputs
	output ssp_pkg::link_pins_s link_out
);
	import ssp_pkg::*;

	localparam int AW = $clog2(FIFO_DEPTH);
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] FULL_CNT = CW'(FIFO_DEPTH);

	function automatic logic [15:0] half_period(input logic [7:0] presc, input logic [7:0] serial_clock_rate);
		logic [16:0] prod;
		prod = 17'(presc) * (17'(serial_clock_rate) + 17'h1);
		half_period = (prod[16:1] == 16'h0) ? 16'h1 : prod[16:1];
	endfunction

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(FIFO_DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	// registers
	ctrl1_s ctrl1_ff, nxt_ctrl1;
	logic [3:0] size_ff, nxt_size;
	logic [7:0] scr_ff, nxt_scr;
	logic [7:0] presc_ff, nxt_presc;
	logic [IRQ_W-1:0] imask_ff, nxt_imask;
	logic [IRQ_W-1:0] istat_ff, nxt_istat;
	// bus phase
	logic wr_pend_ff, nxt_wr_pend;
	logic [7:0] wr_ofs_ff, nxt_wr_ofs;
	logic data_sel_ff, nxt_data_sel;
	logic data_ok_ff, nxt_data_ok;
	logic [31:0] rdata_ff, nxt_rdata;
	// fifo pointers
	logic [AW-1:0] tx_wr_ff, nxt_tx_wr, tx_rd_ff, nxt_tx_rd;
	logic [AW-1:0] rx_wr_ff, nxt_rx_wr, rx_rd_ff, nxt_rx_rd;
	logic [CW-1:0] tx_cnt_ff, nxt_tx_cnt, rx_cnt_ff, nxt_rx_cnt;
	logic tx_avail_ff, nxt_tx_avail;
	// link
	link_state_e state_ff, nxt_state;
	logic [15:0] tx_sh_ff, nxt_tx_sh;
	logic [15:0] rx_sh_ff, nxt_rx_sh;
	logic [3:0] bit_ff, nxt_bit;
	logic [15:0] hcnt_ff, nxt_hcnt;
	link_pins_s pins_ff, nxt_pins;
	// synchronisers
	logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
	logic fss_s1_ff, fss_s2_ff, fss_s3_ff;
	logic sdi_s1_ff, sdi_s2_ff;

	// combinational strobes
	logic tx_push, tx_pop, rx_push, rx_pop;
	logic [15:0] rx_word;
	logic [DATA_W-1:0] tx_q, rx_q;
	logic addr_phase;
	logic [3:0] size_eff;
	logic [15:0] frame_mask;
	logic bit_in;
	logic [IRQ_W-1:0] ev;
	logic [IRQ_W-1:0] clr;

	fifo_mem #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(AW)) u_tx_mem (
		.mclk(mclk),
		.wr_en(tx_push),
		.wr_addr(tx_wr_ff),
		.wr_data(hwdata[DATA_W-1:0]),
		.rd_addr(tx_rd_ff),
		.rd_data(tx_q)
	);

	fifo_mem #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(AW)) u_rx_mem (
		.mclk(mclk),
		.wr_en(rx_push),
		.wr_addr(rx_wr_ff),
		.wr_data(rx_word[DATA_W-1:0]),
		.rd_addr(rx_rd_ff),
		.rd_data(rx_q)
	);

	// outputs
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = data_sel_ff ? (data_ok_ff ? 32'(rx_q) : 32'h0) : rdata_ff;
	assign irq = |(istat_ff & imask_ff);
	assign link_out = pins_ff;

	always_comb
	begin
		addr_phase = hsel && htrans[1] && hready;
		size_eff = (size_ff < SIZE_MIN) ? SIZE_MIN : size_ff;
		frame_mask = 16'hFFFF >> (4'hF - size_eff);
		bit_in = ctrl1_ff.loopback_select ? tx_sh_ff[bit_ff] : sdi_s2_ff;
		rx_word = {rx_sh_ff[14:0], bit_in} & frame_mask;
		tx_push = wr_pend_ff && (wr_ofs_ff == DATA_OFS) && (tx_cnt_ff != FULL_CNT);
		rx_pop = addr_phase && !hwrite && (haddr[7:0] == DATA_OFS) && (rx_cnt_ff != '0);
		tx_pop = 1'b0;
		rx_push = 1'b0;
		ev = '0;
		clr = '0;

		nxt_ctrl1 = ctrl1_ff;
		nxt_size = size_ff;
		nxt_scr = scr_ff;
		nxt_presc = presc_ff;
		nxt_imask = imask_ff;
		nxt_state = state_ff;
		nxt_tx_sh = tx_sh_ff;
		nxt_rx_sh = rx_sh_ff;
		nxt_bit = bit_ff;
		nxt_hcnt = hcnt_ff;
		nxt_pins = pins_ff;

		// bus address phase
		nxt_wr_pend = addr_phase && hwrite;
		nxt_wr_ofs = haddr[7:0];
		nxt_data_sel = addr_phase && !hwrite && (haddr[7:0] == DATA_OFS);
		nxt_data_ok = rx_pop;
		nxt_rdata = 32'h0;
		if (addr_phase && !hwrite)
		begin
			if (haddr[7:0] == CTRL0_OFS)
			begin
				nxt_rdata = 32'(size_ff) | (32'(scr_ff) << SCR_LSB);
			end
			else if (haddr[7:0] == CTRL1_OFS)
			begin
				nxt_rdata = 32'(ctrl1_ff);
			end
			else if (haddr[7:0] == FLAGS_OFS)
			begin
				nxt_rdata[FLAG_BUSY] = (state_ff != LINK_IDLE) || (tx_cnt_ff != '0);
				nxt_rdata[FLAG_RX_FULL] = rx_cnt_ff == FULL_CNT;
				nxt_rdata[FLAG_RX_DATA] = rx_cnt_ff != '0;
				nxt_rdata[FLAG_TX_SPACE] = tx_cnt_ff != FULL_CNT;
				nxt_rdata[FLAG_TX_EMPTY] = tx_cnt_ff == '0;
			end
			else if (haddr[7:0] == PRESC_OFS)
			begin
				nxt_rdata = 32'({presc_ff[7:1], 1'b0});
			end
			else if (haddr[7:0] == IMASK_OFS)
			begin
				nxt_rdata = 32'(imask_ff);
			end
			else if (haddr[7:0] == ISTAT_OFS)
			begin
				nxt_rdata = 32'(istat_ff);
				clr = istat_ff;
			end
			else
			begin
				nxt_rdata = 32'h0;
			end
		end

		// bus data phase writes
		if (wr_pend_ff)
		begin
			if (wr_ofs_ff == CTRL0_OFS)
			begin
				nxt_size = hwdata[SIZE_LSB +: 4];
				nxt_scr = hwdata[SCR_LSB +: 8];
			end
			else if (wr_ofs_ff == CTRL1_OFS)
			begin
				nxt_ctrl1 = hwdata[3:0];
			end
			else if (wr_ofs_ff == PRESC_OFS)
			begin
				nxt_presc = {hwdata[7:1], 1'b0};
			end
			else if (wr_ofs_ff == IMASK_OFS)
			begin
				nxt_imask = hwdata[IRQ_W-1:0];
			end
		end

		// link shifter
		case (state_ff)
			LINK_IDLE:
			begin
				nxt_pins.fss_out = 1'b1;
				nxt_pins.sclk_out = 1'b0;
				if (ctrl1_ff.port_enable && !ctrl1_ff.role_select && tx_avail_ff)
				begin
					tx_pop = 1'b1;
					nxt_tx_sh = 16'(tx_q) & frame_mask;
					nxt_rx_sh = 16'h0;
					nxt_bit = size_eff;
					nxt_hcnt = half_period(presc_ff, scr_ff);
					nxt_pins.fss_out = 1'b0;
					nxt_state = LINK_LOW;
				end
				else if (ctrl1_ff.port_enable && ctrl1_ff.role_select && !fss_s2_ff && fss_s3_ff)
				begin
					tx_pop = tx_avail_ff;
					nxt_tx_sh = tx_avail_ff ? (16'(tx_q) & frame_mask) : 16'h0;
					nxt_rx_sh = 16'h0;
					nxt_bit = size_eff;
					nxt_state = LINK_SLAVE;
				end
			end
			LINK_LOW:
			begin
				if (hcnt_ff == 16'h1)
				begin
					nxt_hcnt = half_period(presc_ff, scr_ff);
					nxt_pins.sclk_out = 1'b1;
					nxt_state = LINK_HIGH;
				end
				else
				begin
					nxt_hcnt = hcnt_ff - 16'h1;
				end
			end
			LINK_HIGH:
			begin
				if (hcnt_ff == 16'h1)
				begin
					nxt_hcnt = half_period(presc_ff, scr_ff);
					nxt_pins.sclk_out = 1'b0;
					nxt_rx_sh = {rx_sh_ff[14:0], bit_in};
					if (bit_ff == 4'h0)
					begin
						rx_push = 1'b1;
						nxt_state = LINK_IDLE;
						nxt_pins.fss_out = 1'b1;
					end
					else
					begin
						nxt_bit = bit_ff - 4'h1;
						nxt_state = LINK_LOW;
					end
				end
				else
				begin
					nxt_hcnt = hcnt_ff - 16'h1;
				end
			end
			LINK_SLAVE:
			begin
				if (fss_s2_ff)
				begin
					nxt_state = LINK_IDLE;
				end
				else if (sclk_s2_ff && !sclk_s3_ff)
				begin
					nxt_rx_sh = {rx_sh_ff[14:0], bit_in};
					if (bit_ff == 4'h0)
					begin
						rx_push = 1'b1;
						nxt_state = LINK_IDLE;
					end
				end
				else if (!sclk_s2_ff && sclk_s3_ff && bit_ff != 4'h0)
				begin
					nxt_bit = bit_ff - 4'h1;
				end
			end
			default:
			begin
				nxt_state = LINK_IDLE;
			end
		endcase

		// disabling aborts any frame
		if (!ctrl1_ff.port_enable)
		begin
			nxt_state = LINK_IDLE;
			nxt_pins.fss_out = 1'b1;
			nxt_pins.sclk_out = 1'b0;
		end

		nxt_pins.sclk_oe = ctrl1_ff.port_enable && !ctrl1_ff.role_select;
		nxt_pins.fss_oe = ctrl1_ff.port_enable && !ctrl1_ff.role_select;
		nxt_pins.serial_data_out_pin = (nxt_state == LINK_IDLE) ? 1'b0 : nxt_tx_sh[nxt_bit];
		if (ctrl1_ff.role_select)
		begin
			nxt_pins.serial_data_oe = ctrl1_ff.port_enable && !ctrl1_ff.slave_output_off
				&& (nxt_state == LINK_SLAVE);
		end
		else
		begin
			nxt_pins.serial_data_oe = ctrl1_ff.port_enable;
		end

		// fifo bookkeeping
		rx_push = rx_push && (rx_cnt_ff != FULL_CNT);
		ev[IRQ_OVERRUN] = (state_ff != LINK_IDLE) && (nxt_state == LINK_IDLE)
			&& (rx_cnt_ff == FULL_CNT) && (nxt_rx_sh != rx_sh_ff || state_ff == LINK_HIGH)
			&& !ctrl1_ff.port_enable == 1'b0 && !rx_push && (fss_s2_ff == 1'b0
			|| state_ff == LINK_HIGH);
		ev[IRQ_RX_WORD] = rx_push;
		ev[IRQ_TX_DONE] = (state_ff != LINK_IDLE) && (nxt_state == LINK_IDLE) && (tx_cnt_ff == '0);
		nxt_istat = (istat_ff & ~clr) | ev;
		nxt_tx_wr = tx_push ? ptr_inc(tx_wr_ff) : tx_wr_ff;
		nxt_tx_rd = tx_pop ? ptr_inc(tx_rd_ff) : tx_rd_ff;
		nxt_rx_wr = rx_push ? ptr_inc(rx_wr_ff) : rx_wr_ff;
		nxt_rx_rd = rx_pop ? ptr_inc(rx_rd_ff) : rx_rd_ff;
		nxt_tx_cnt = tx_cnt_ff + CW'(tx_push) - CW'(tx_pop);
		nxt_rx_cnt = rx_cnt_ff + CW'(rx_push) - CW'(rx_pop);
		nxt_tx_avail = (tx_cnt_ff != '0) && !tx_pop;
	end

	always_ff @(posedge mclk)
	begin
		sclk_s1_ff <= sclk_in;
		sclk_s2_ff <= sclk_s1_ff;
		sclk_s3_ff <= sclk_s2_ff;
		fss_s1_ff <= fss_in;
		fss_s2_ff <= fss_s1_ff;
		fss_s3_ff <= fss_s2_ff;
		sdi_s1_ff <= serial_data_in;
		sdi_s2_ff <= sdi_s1_ff;
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			ctrl1_ff <= CTRL1_RST;
			size_ff <= SIZE_RST;
			scr_ff <= SCR_RST;
			presc_ff <= PRESC_RST;
			imask_ff <= IRQ_RST;
			istat_ff <= IRQ_RST;
			wr_pend_ff <= 1'b0;
			wr_ofs_ff <= 8'h00;
			data_sel_ff <= 1'b0;
			data_ok_ff <= 1'b0;
			rdata_ff <= 32'h0;
			tx_wr_ff <= '0;
			tx_rd_ff <= '0;
			rx_wr_ff <= '0;
			rx_rd_ff <= '0;
			tx_cnt_ff <= '0;
			rx_cnt_ff <= '0;
			tx_avail_ff <= 1'b0;
			state_ff <= LINK_IDLE;
			tx_sh_ff <= 16'h0;
			rx_sh_ff <= 16'h0;
			bit_ff <= 4'h0;
			hcnt_ff <= 16'h1;
			pins_ff <= LINK_RST;
		end
		else
		begin
			ctrl1_ff <= nxt_ctrl1;
			size_ff <= nxt_size;
			scr_ff <= nxt_scr;
			presc_ff <= nxt_presc;
			imask_ff <= nxt_imask;
			istat_ff <= nxt_istat;
			wr_pend_ff <= nxt_wr_pend;
			wr_ofs_ff <= nxt_wr_ofs;
			data_sel_ff <= nxt_data_sel;
			data_ok_ff <= nxt_data_ok;
			rdata_ff <= nxt_rdata;
			tx_wr_ff <= nxt_tx_wr;
			tx_rd_ff <= nxt_tx_rd;
			rx_wr_ff <= nxt_rx_wr;
			rx_rd_ff <= nxt_rx_rd;
			tx_cnt_ff <= nxt_tx_cnt;
			rx_cnt_ff <= nxt_rx_cnt;
			tx_avail_ff <= nxt_tx_avail;
			state_ff <= nxt_state;
			tx_sh_ff <= nxt_tx_sh;
			rx_sh_ff <= nxt_rx_sh;
			bit_ff <= nxt_bit;
			hcnt_ff <= nxt_hcnt;
			pins_ff <= nxt_pins;
		end
	end
endmodule

// File: ssp_ctrl_status_asserts.sv
// port assertions of the serial port block
`timescale 1ns/1ns
module ssp_ctrl_status_asserts
	import ssp_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// interrupt and link
	input wire logic irq,
	input wire ssp_pkg::link_pins_s link_out
);
	logic ph_ff;
	logic wr_ff;
	logic [7:0] ad_ff;
	logic [3:0] cr_ff;
	logic [3:0] nxt_cr;
	logic [2:0] mk_ff;
	logic [2:0] nxt_mk;
	logic rd_ph;
	assign rd_ph = ph_ff & ~wr_ff;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	// shadow of control and mask writes
	always_comb
	begin
		nxt_cr = cr_ff;
		nxt_mk = mk_ff;
		if (ph_ff && wr_ff && ad_ff == CTRL1_OFS)
			nxt_cr = hwdata[3:0];
		if (ph_ff && wr_ff && ad_ff == IMASK_OFS)
			nxt_mk = hwdata[2:0];
	end
	always_ff @(posedge mclk)
	begin
		ph_ff <= resetn & hsel & htrans[1] & hready;
		wr_ff <= hwrite;
		ad_ff <= haddr[7:0];
		cr_ff <= resetn ? nxt_cr : 4'h0;
		mk_ff <= resetn ? nxt_mk : 3'h0;
	end
	ready_ok_a: assert property (hreadyout && !hresp)
		else $error("bus wait or error response");
	rdata_idle_a: assert property (!ph_ff |-> hrdata == 32'h0)
		else $error("read data outside data phase");
	unmapped_zero_a: assert property (rd_ph && ad_ff > ISTAT_OFS |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	tx_flags_a: assert property (
		rd_ph && ad_ff == FLAGS_OFS && hrdata[FLAG_TX_EMPTY] |-> hrdata[FLAG_TX_SPACE])
		else $error("tx fifo empty and full");
	rx_flags_a: assert property (
		rd_ph && ad_ff == FLAGS_OFS && hrdata[FLAG_RX_FULL] |-> hrdata[FLAG_RX_DATA])
		else $error("rx fifo full and empty");
	sod_quiet_a: assert property (
		cr_ff[CR1_ROLE] && cr_ff[CR1_OUT_OFF] && $past(cr_ff[CR1_ROLE] & cr_ff[CR1_OUT_OFF])
		|-> !link_out.serial_data_oe)
		else $error("slave data driven while off");
	idle_off_a: assert property (
		!cr_ff[CR1_ENABLE] && !$past(cr_ff[CR1_ENABLE]) && !$past(cr_ff[CR1_ENABLE], 2)
		|-> link_out.fss_out && !link_out.sclk_out)
		else $error("disabled port shifting");
	frame_start_a: assert property (
		$fell(link_out.fss_out) |-> !cr_ff[CR1_ROLE] && cr_ff[CR1_ENABLE])
		else $error("frame started outside enabled master");
	slave_clk_a: assert property (
		cr_ff[CR1_ROLE] && $past(cr_ff[CR1_ROLE]) && $past(cr_ff[CR1_ROLE], 2)
		|-> !link_out.sclk_oe && !link_out.fss_oe)
		else $error("slave drives clock or select");
	clk_frame_a: assert property (link_out.sclk_out |-> !link_out.fss_out)
		else $error("clock outside frame");
	irq_mask_a: assert property (mk_ff == 3'h0 |-> !irq)
		else $error("irq with all masked");
endmodule
bind ssp_ctrl_status ssp_ctrl_status_asserts chk (.mclk(mclk), .resetn(resetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .link_out(link_out));

// File: ssp_peer.sv
// serial peer on the link, slave or master
`timescale 1ns/1ns
module ssp_peer
	import ssp_pkg::*;
#(
	parameter int BITS = 8
)(
	// device pins
	input wire ssp_pkg::link_pins_s link_out,
	output logic sclk_in,
	output logic fss_in,
	output logic serial_data_in,
	// bench side
	input wire logic go,
	input wire logic [15:0] reply,
	output logic [15:0] heard,
	output logic busy
);
	logic [15:0] sh;
	logic pin;
	// released data line shows the inverse of its last value
	assign pin = link_out.serial_data_oe ? link_out.serial_data_out_pin : ~heard[0];
	initial
	begin
		sclk_in = 1'b0;
		fss_in = 1'b1;
		serial_data_in = 1'b0;
		heard = 16'h0;
		busy = 1'b0;
		sh = 16'h0;
	end
	// slave to the device: msb first, change after falling clock
	always @(negedge link_out.fss_out)
	begin
		sh = reply;
		serial_data_in = sh[BITS-1];
	end
	always @(posedge link_out.sclk_out)
		heard = {heard[14:0], pin};
	always @(negedge link_out.sclk_out)
	begin
		sh = sh << 1;
		serial_data_in = sh[BITS-1];
	end
	always @(posedge link_out.fss_out)
		serial_data_in = ~serial_data_in;
	// master to the device: clock runs only within the frame
	always @(posedge go)
	begin
		busy = 1'b1;
		sh = reply;
		fss_in = 1'b0;
		serial_data_in = sh[BITS-1];
		repeat (BITS)
		begin
			#63 sclk_in = 1'b1;
			heard = {heard[14:0], pin};
			#62 sclk_in = 1'b0;
			sh = sh << 1;
			serial_data_in = sh[BITS-1];
		end
		#63 fss_in = 1'b1;
		serial_data_in = ~serial_data_in;
		busy = 1'b0;
	end
endmodule

// File: tb_ssp_ctrl_status.sv
// testbench of the serial port block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_ssp_ctrl_status;
	import ssp_pkg::*;
	logic mclk, resetn, hsel, hwrite, hreadyout, hresp, irq, go;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic sclk_in, fss_in, serial_data_in;
	logic [15:0] reply, heard;
	logic busy;
	link_pins_s link_out;
	int n_errors = 0;
	int checks = 0;
	ssp_ctrl_status uut (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .sclk_in(sclk_in),
		.fss_in(fss_in), .serial_data_in(serial_data_in), .link_out(link_out));
	ssp_peer peer (.link_out(link_out), .sclk_in(sclk_in), .fss_in(fss_in),
		.serial_data_in(serial_data_in), .go(go), .reply(reply), .heard(heard), .busy(busy));
	task automatic stop_test;
		if (n_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wait_ready;
		int i = 0;
		@(posedge mclk);
		while (hreadyout !== 1'b1 && i < 50)
		begin
			@(posedge mclk);
			i++;
		end
		if (hreadyout !== 1'b1)
		begin
			n_errors++;
			stop_test;
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready;
		rd = hrdata;
	endtask
	task automatic rdx(input logic [7:0] a, input logic [31:0] e, input string nm);
		xfer(1'b0, a, 32'h0);
		`CHK(nm, e, rd)
	endtask
	task automatic irqx(input logic e);
		@(negedge mclk);
		`CHK("irq", e, irq)
		@(posedge mclk);
	endtask
	task automatic poll(input logic [31:0] m, input logic [31:0] v);
		int i;
		for (i = 0; i < 400; i++)
		begin
			xfer(1'b0, FLAGS_OFS, 32'h0);
			if ((rd & m) === v)
				break;
		end
		if (i == 400)
		begin
			n_errors++;
			stop_test;
		end
	endtask
	task automatic frame(input logic [15:0] r);
		int i;
		reply <= r;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		for (i = 0; i < 300 && busy; i++)
			@(posedge mclk);
		if (busy)
		begin
			n_errors++;
			stop_test;
		end
		poll(32'h4, 32'h4);
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		{resetn, hsel, hwrite, go, htrans, haddr, hwdata, reply} = '0;
		hsize = 3'h2;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		rdx(FLAGS_OFS, 32'h3, "flags reset");
		rdx(8'h1C, 32'h0, "unmapped");
		rdx(DATA_OFS, 32'h0, "empty rx");
		xfer(1'b1, CTRL0_OFS, 32'h7);
		xfer(1'b1, PRESC_OFS, 32'h8);
		xfer(1'b1, IMASK_OFS, 32'h2);
		xfer(1'b1, DATA_OFS, 32'h1A5);
		reply <= 16'h5C;
		repeat (40) @(posedge mclk);
		rdx(FLAGS_OFS, 32'h12, "flags held");
		xfer(1'b1, CTRL1_OFS, 32'h2);
		poll(32'h10, 32'h0);
		`CHK("peer heard", 8'hA5, heard[7:0])
		rdx(FLAGS_OFS, 32'h7, "flags rx");
		irqx(1'b1);
		xfer(1'b1, IMASK_OFS, 32'h0);
		irqx(1'b0);
		xfer(1'b1, IMASK_OFS, 32'h2);
		irqx(1'b1);
		rdx(ISTAT_OFS, 32'h6, "int status");
		irqx(1'b0);
		rdx(DATA_OFS, 32'h5C, "rx word");
		xfer(1'b1, CTRL1_OFS, 32'h0);
		for (int k = 0; k < 9; k++)
			xfer(1'b1, DATA_OFS, 32'h0F30 + k);
		rdx(FLAGS_OFS, 32'h10, "tx full");
		xfer(1'b1, CTRL1_OFS, 32'h3);
		poll(32'h10, 32'h0);
		rdx(FLAGS_OFS, 32'hF, "rx full");
		for (int k = 0; k < 8; k++)
			rdx(DATA_OFS, 32'h30 + k, "loop word");
		rdx(FLAGS_OFS, 32'h3, "flags drained");
		xfer(1'b1, CTRL1_OFS, 32'h4);
		xfer(1'b1, PRESC_OFS, 32'h2);
		xfer(1'b1, CTRL0_OFS, 32'h7);
		xfer(1'b1, DATA_OFS, 32'h3C);
		xfer(1'b1, CTRL1_OFS, 32'h6);
		frame(16'h96);
		`CHK("slave out", 8'h3C, heard[7:0])
		rdx(DATA_OFS, 32'h96, "slave in");
		xfer(1'b1, CTRL1_OFS, 32'hE);
		frame(16'h69);
		`CHK("quiet out", 8'hAA, heard[7:0])
		rdx(DATA_OFS, 32'h69, "slave quiet in");
		stop_test;
	end
endmodule
